// File: logic/gpp_cfg.svh
/*
  Constants of the parallel port lines: group widths, register offsets and
  reset values. Included by every design file of the block; holds only
  definitions.
*/
// How it works
// [RULE1] Forty-eight usable pin lines in total across all groups.
// [RULE2] Three bidirectional groups plus one group that only takes input.
// [RULE3] Input-only group has 14 lines, never driven as outputs.
// [RULE4] Bidirectional groups are 14, 4 and 16 lines wide.
// [RULE5] Each line readable and writable alone, without touching its group.
// [RULE6] Per-line direction, push-pull or open-drain, and pull enable.
// [RULE7] Per-line control also picks edge shape and drive strength.
// [RULE8] A line set as input releases its driver to high impedance.
// [RULE9] During reset every line is input with pulls off.
// [RULE10] Alternate functions routable by software to a choice of pins.
// [RULE11] Lines not claimed by alternate functions serve as plain I/O.
// [RULE12] Pin inputs pass two flip-flops before anyone observes them.
`ifndef GPP_CFG_SVH
`define GPP_CFG_SVH

// Group widths, in line order a, input-only, c, d
`define GPP_W_A 14
`define GPP_W_IN 14
`define GPP_W_C 4
`define GPP_W_D 16
`define GPP_LINES 48
`define GPP_GROUPS 4
`define GPP_IN_GROUP 1
`define GPP_GRP_C 2
`define GPP_N_ALT 4

// Register port
`define GPP_AW 8
`define GPP_DW 16
`define GPP_PIN_W 6
`define GPP_MAX_LINES 64

// Register offsets
`define GPP_OUT_BASE 8'h00
`define GPP_IN_BASE 8'h04
`define GPP_BIT_BASE 8'h40
`define GPP_CTL_BASE 8'h80
`define GPP_ROUTE_BASE 8'hc0
`define GPP_INSEL_BASE 8'hd0

// Reset values
`define GPP_CTL_RST 7'h00
`define GPP_ROUTE_RST 7'h00
`define GPP_INSEL_RST 6'h00

`endif

// File: logic/gpp_pkg.sv
/*
  Types of the parallel port lines: per-line control, pad shaping and
  alternate output route. Assumes gpp_cfg.svh for widths.
*/
`include "gpp_cfg.svh"

package gpp_pkg;

    typedef struct packed {
        logic [1:0] drive;
        logic slow_edge;
        logic pull_up;
        logic pull_en;
        logic open_drain;
        logic dir_out;
    } gpp_ctl_s;

    typedef struct packed {
        logic [1:0] drive;
        logic slow_edge;
        logic pull_up;
        logic pull_en;
    } gpp_pad_s;

    typedef struct packed {
        logic en;
        logic [`GPP_PIN_W-1:0] pin;
    } gpp_route_s;

endpackage

// File: logic/gpp_sync.sv
/*
  Two flip-flop synchroniser for a vector of pin levels.
  Assumes the inputs are asynchronous to clk; only the second stage leaves.
*/
`include "gpp_cfg.svh"

module gpp_sync #(
    parameter int W = `GPP_LINES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Levels
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1_q, s1_d, s2_q, s2_d;

    always_comb begin
        s1_d = din;
        s2_d = s1_q;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
        end
    end

    assign dout = s2_q;
endmodule

// File: logic/gpp_line.sv
/*
  One port line: output latch, control settings and registered pad drive.
  Assumes write strobes are one cycle and decoded by the port block.
*/
`include "gpp_cfg.svh"

module gpp_line #(
    parameter bit CAN_DRIVE = 1'b1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Software side
    input wire logic out_we,
    input wire logic out_wbit,
    input wire logic ctl_we,
    input gpp_pkg::gpp_ctl_s ctl_wdata,
    // Alternate function
    input wire logic alt_en,
    input wire logic alt_val,
    // State and pad
    output logic out_q,
    output gpp_pkg::gpp_ctl_s ctl_q,
    output logic pad_out_q,
    output logic pad_oe_q,
    output gpp_pkg::gpp_pad_s pad_q
);
    import gpp_pkg::*;

    logic out_d, pad_out_d, pad_oe_d, drive_val;
    gpp_ctl_s ctl_d;
    gpp_pad_s pad_d;

    always_comb begin
        out_d = out_we ? out_wbit : out_q; // RULE5
        ctl_d = ctl_we ? ctl_wdata : ctl_q; // RULE6
        if (!CAN_DRIVE) begin
            ctl_d.dir_out = 1'b0; // RULE3
            ctl_d.open_drain = 1'b0;
        end
        // Peripheral takes over the line; latch stays for later use
        drive_val = alt_en ? alt_val : out_q; // RULE10 RULE11
        // Open drain only ever pulls low
        pad_oe_d = CAN_DRIVE && ctl_q.dir_out && // RULE8
            !(ctl_q.open_drain && drive_val); // RULE6
        pad_out_d = drive_val && !ctl_q.open_drain;
        pad_d.drive = ctl_q.drive; // RULE7
        pad_d.slow_edge = ctl_q.slow_edge;
        pad_d.pull_up = ctl_q.pull_up;
        pad_d.pull_en = ctl_q.pull_en;
    end

    // Zero control is input, pulls off
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_q <= 1'b0;
            ctl_q <= `GPP_CTL_RST; // RULE9
            pad_out_q <= 1'b0;
            pad_oe_q <= 1'b0;
            pad_q <= '0;
        end else begin
            out_q <= out_d;
            ctl_q <= ctl_d;
            pad_out_q <= pad_out_d;
            pad_oe_q <= pad_oe_d;
            pad_q <= pad_d;
        end
    end

    property p_input_release;
        @(posedge clk) disable iff (rst)
        !ctl_q.dir_out |=> !pad_oe_q;
    endproperty
    a_input_release: assert property (p_input_release) // RULE8
        else $error("input line still drives its pad");

    property p_od_no_high;
        @(posedge clk) disable iff (rst)
        ctl_q.open_drain |=> !(pad_oe_q && pad_out_q);
    endproperty
    a_od_no_high: assert property (p_od_no_high) // RULE6
        else $error("open-drain line drives high");

    property p_pad_shape;
        @(posedge clk) disable iff (rst)
        ctl_we ##1 !ctl_we |=> pad_q.drive == $past(ctl_wdata.drive, 2) &&
            pad_q.slow_edge == $past(ctl_wdata.slow_edge, 2);
    endproperty
    a_pad_shape: assert property (p_pad_shape) // RULE7
        else $error("pad shape does not follow control");
endmodule

// File: logic/gpp_top.sv
/*
  Parallel port lines: bidirectional groups and one input-only group,
  a plain register port, alternate function routing and pad controls.
  Assumes strobes one cycle long and never both at once; pads resolved
  outside from pad_out and pad_oe.
*/
// Chosen here: the register offsets and the address-and-strobe port.
`include "gpp_cfg.svh"

module gpp_top #(
    parameter int W_A = `GPP_W_A,
    parameter int W_IN = `GPP_W_IN,
    parameter int W_C = `GPP_W_C,
    parameter int W_D = `GPP_W_D,
    parameter int N_AO = `GPP_N_ALT,
    parameter int N_AI = `GPP_N_ALT,
    parameter int NL = W_A + W_IN + W_C + W_D
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [`GPP_AW-1:0] addr,
    input wire logic [`GPP_DW-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [`GPP_DW-1:0] rdata,
    // Pads
    input wire logic [NL-1:0] pad_in,
    output logic [NL-1:0] pad_out,
    output logic [NL-1:0] pad_oe,
    output gpp_pkg::gpp_pad_s [NL-1:0] pad_ctl,
    // Peripherals
    input wire logic [N_AO-1:0] alt_out,
    output logic [N_AI-1:0] alt_in,
    output logic [NL-1:0] sync_in
);
    import gpp_pkg::*;

    localparam int LO_IN = W_A;
    localparam int LO_C = LO_IN + W_IN;
    localparam int LO_D = LO_C + W_C;
    localparam int GLO [`GPP_GROUPS] = '{0, LO_IN, LO_C, LO_D};
    localparam int GW [`GPP_GROUPS] = '{W_A, W_IN, W_C, W_D};

    function automatic int grp_of(input int i);
        if (i < LO_IN) return 0;
        if (i < LO_C) return 1;
        if (i < LO_D) return 2;
        return 3;
    endfunction

    // Line count is fixed by the line total and group shape by the data word width
    if (NL != `GPP_LINES) begin : g_chk_total
        $error("line total must be 48"); // RULE1
    end
    if (W_A > `GPP_DW || W_IN > `GPP_DW || W_C > `GPP_DW ||
            W_D > `GPP_DW || W_A < 1 || W_IN < 1 || W_C < 1 ||
            W_D < 1) begin : g_chk_grp
        $error("group width must be 1 to 16"); // RULE2 RULE4
    end
    if (N_AO < 1 || N_AI < 1 || N_AO > 16 || N_AI > 16) begin : g_chk_alt
        $error("alternate function count must be 1 to 16");
    end

    logic [NL-1:0] out_vec, alt_en, alt_val, dir_vec, od_vec, pull_vec;
    logic [NL-1:0] bit_exp;
    gpp_ctl_s ctl_arr [NL];
    gpp_route_s route_q [N_AO];
    gpp_route_s route_d [N_AO];
    logic [`GPP_PIN_W-1:0] insel_q [N_AI];
    logic [`GPP_PIN_W-1:0] insel_d [N_AI];
    logic [N_AI-1:0] alt_in_q, alt_in_d;
    logic [`GPP_DW-1:0] rdata_q, rdata_d;

    gpp_sync #(
        .W(NL)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .din(pad_in),
        .dout(sync_in) // RULE12
    );

    for (genvar i = 0; i < NL; i++) begin : g_line
        localparam int G = grp_of(i);
        localparam int OFF = i - GLO[G];
        logic hit_bit, hit_word, we, wbit, cwe;
        assign hit_bit = addr == `GPP_BIT_BASE + `GPP_AW'(i);
        assign hit_word = addr == `GPP_OUT_BASE + `GPP_AW'(G);
        assign we = wr && (hit_bit || hit_word); // RULE5
        assign wbit = hit_bit ? wdata[0] : wdata[OFF];
        assign cwe = wr && addr == `GPP_CTL_BASE + `GPP_AW'(i);
        gpp_line #(
            .CAN_DRIVE(G != `GPP_IN_GROUP) // RULE3
        ) u_line (
            .clk(clk),
            .rst(rst),
            .out_we(we),
            .out_wbit(wbit),
            .ctl_we(cwe),
            .ctl_wdata(gpp_ctl_s'(wdata[$bits(gpp_ctl_s)-1:0])),
            .alt_en(alt_en[i]),
            .alt_val(alt_val[i]),
            .out_q(out_vec[i]),
            .ctl_q(ctl_arr[i]),
            .pad_out_q(pad_out[i]),
            .pad_oe_q(pad_oe[i]),
            .pad_q(pad_ctl[i])
        );
        assign dir_vec[i] = ctl_arr[i].dir_out;
        assign od_vec[i] = ctl_arr[i].open_drain;
        assign pull_vec[i] = pad_ctl[i].pull_en;
    end

    // Pin claim; lowest function number wins a shared pin
    always_comb begin
        alt_en = '0;
        alt_val = '0;
        for (int i = 0; i < NL; i++) begin
            for (int f = N_AO - 1; f >= 0; f--) begin
                if (route_q[f].en && route_q[f].pin == `GPP_PIN_W'(i)) begin
                    alt_en[i] = 1'b1; // RULE10
                    alt_val[i] = alt_out[f];
                end
            end
        end
    end

    // Route and input select registers
    always_comb begin
        for (int f = 0; f < N_AO; f++) begin
            route_d[f] = route_q[f];
            if (wr && addr == `GPP_ROUTE_BASE + `GPP_AW'(f))
                route_d[f] = gpp_route_s'(wdata[`GPP_PIN_W:0]);
        end
        for (int f = 0; f < N_AI; f++) begin
            insel_d[f] = insel_q[f];
            if (wr && addr == `GPP_INSEL_BASE + `GPP_AW'(f))
                insel_d[f] = wdata[`GPP_PIN_W-1:0];
            // Unused pin numbers read low rather than unknown
            alt_in_d[f] = (int'(insel_q[f]) < NL) ?
                sync_in[insel_q[f]] : 1'b0; // RULE10
        end
    end

    // Read data stand only in the cycle after the strobe
    always_comb begin
        rdata_d = '0;
        if (rd) begin
            for (int g = 0; g < `GPP_GROUPS; g++) begin
                for (int b = 0; b < GW[g]; b++) begin
                    if (addr == `GPP_OUT_BASE + `GPP_AW'(g))
                        rdata_d[b] = out_vec[GLO[g] + b];
                    if (addr == `GPP_IN_BASE + `GPP_AW'(g))
                        rdata_d[b] = sync_in[GLO[g] + b]; // RULE12
                end
            end
            for (int i = 0; i < NL; i++) begin
                if (addr == `GPP_BIT_BASE + `GPP_AW'(i))
                    rdata_d = {14'h0, sync_in[i], out_vec[i]}; // RULE5
                if (addr == `GPP_CTL_BASE + `GPP_AW'(i))
                    rdata_d = {9'h0, ctl_arr[i]}; // RULE6
            end
            for (int f = 0; f < N_AO; f++) begin
                if (addr == `GPP_ROUTE_BASE + `GPP_AW'(f))
                    rdata_d = {9'h0, route_q[f]};
            end
            for (int f = 0; f < N_AI; f++) begin
                if (addr == `GPP_INSEL_BASE + `GPP_AW'(f))
                    rdata_d = {10'h0, insel_q[f]};
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int f = 0; f < N_AO; f++) route_q[f] <= `GPP_ROUTE_RST;
            for (int f = 0; f < N_AI; f++) insel_q[f] <= `GPP_INSEL_RST;
            alt_in_q <= '0;
            rdata_q <= '0;
        end else begin
            for (int f = 0; f < N_AO; f++) route_q[f] <= route_d[f];
            for (int f = 0; f < N_AI; f++) insel_q[f] <= insel_d[f];
            alt_in_q <= alt_in_d;
            rdata_q <= rdata_d;
        end
    end

    assign alt_in = alt_in_q;
    assign rdata = rdata_q;

    // Expected latch after a single-bit write
    always_comb begin
        bit_exp = out_vec;
        for (int i = 0; i < NL; i++) begin
            if (addr == `GPP_BIT_BASE + `GPP_AW'(i))
                bit_exp[i] = wdata[0];
        end
    end

    sequence s_bit_wr;
        wr && addr >= `GPP_BIT_BASE &&
            addr < `GPP_BIT_BASE + `GPP_AW'(NL);
    endsequence

    sequence s_settled;
        !rst [*3];
    endsequence

    property p_bit_write;
        @(posedge clk) disable iff (rst)
        s_bit_wr |=> out_vec == $past(bit_exp);
    endproperty
    a_bit_write: assert property (p_bit_write) // RULE5
        else $error("single-bit write disturbed its group");

    property p_in_only_quiet;
        @(posedge clk) disable iff (rst)
        pad_oe[LO_IN +: W_IN] == '0;
    endproperty
    a_in_only_quiet: assert property (p_in_only_quiet) // RULE3
        else $error("input-only line drives its pad");

    property p_reset_inputs;
        @(posedge clk)
        rst |-> pad_oe == '0 && pull_vec == '0;
    endproperty
    a_reset_inputs: assert property (p_reset_inputs) // RULE9
        else $error("line not input without pulls in reset");

    property p_gp_drive;
        @(posedge clk) disable iff (rst)
        1'b1 |=> ((pad_out ^ $past(out_vec)) &
            $past(~alt_en & dir_vec & ~od_vec)) == '0;
    endproperty
    a_gp_drive: assert property (p_gp_drive) // RULE11
        else $error("free line does not show its latch");

    property p_alt_drive;
        @(posedge clk) disable iff (rst)
        1'b1 |=> ((pad_out ^ $past(alt_val)) &
            $past(alt_en & dir_vec & ~od_vec)) == '0;
    endproperty
    a_alt_drive: assert property (p_alt_drive) // RULE10
        else $error("claimed line does not follow its function");

    property p_sync_delay;
        @(posedge clk) disable iff (rst)
        s_settled |-> sync_in == $past(pad_in, 2);
    endproperty
    a_sync_delay: assert property (p_sync_delay) // RULE12
        else $error("input not seen two cycles after the pin");

    // Pads only ever drive when the line is an output
    property p_dir_release;
        @(posedge clk) disable iff (rst)
        1'b1 |=> (pad_oe & ~$past(dir_vec)) == '0;
    endproperty
    a_dir_release: assert property (p_dir_release) // RULE8
        else $error("line set as input enables its driver");

    property p_od_low;
        @(posedge clk) disable iff (rst)
        1'b1 |=> (pad_out & $past(od_vec)) == '0;
    endproperty
    a_od_low: assert property (p_od_low) // RULE6
        else $error("open-drain line shows a high level");

    property p_in_only_ctl;
        @(posedge clk) disable iff (rst)
        (dir_vec[LO_IN +: W_IN] | od_vec[LO_IN +: W_IN]) == '0;
    endproperty
    a_in_only_ctl: assert property (p_in_only_ctl) // RULE3
        else $error("input-only line holds an output setting");

    sequence s_word_wr_c;
        wr && addr == `GPP_OUT_BASE + `GPP_AW'(`GPP_GRP_C);
    endsequence

    property p_word_write;
        @(posedge clk) disable iff (rst)
        s_word_wr_c |=> out_vec[LO_C +: W_C] == $past(wdata[W_C-1:0]);
    endproperty
    a_word_write: assert property (p_word_write) // RULE4 RULE5
        else $error("group word write not taken by its lines");

    // Read data must not linger past their one cycle
    property p_rdata_idle;
        @(posedge clk) disable iff (rst)
        !rd |=> rdata == '0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data stand without a read");

    // Each selected peripheral input follows its synchronised pin level one cycle later
    for (genvar f = 0; f < N_AI; f++) begin : g_alt_in_chk
        property p_alt_in_pick;
            @(posedge clk) disable iff (rst)
            int'(insel_q[f]) < NL |=>
                alt_in[f] == $past(sync_in[insel_q[f]]);
        endproperty
        a_alt_in_pick: assert property (p_alt_in_pick) // RULE10 RULE12
            else $error("peripheral input does not follow its pin");

        property p_alt_in_none;
            @(posedge clk) disable iff (rst)
            int'(insel_q[f]) >= NL |=> !alt_in[f];
        endproperty
        a_alt_in_none: assert property (p_alt_in_none) // RULE10
            else $error("unused pin number gives a peripheral level");
    end
endmodule

// File: sim/gpp_pins_model.sv
/*
  Pin side of the port lines: resolves each pad level from the device
  driver, an external driver and the pull devices.
  Assumes one clock; a pad nobody drives or pulls wanders every cycle.
*/
module gpp_pins_model import gpp_pkg::*; (
    // Clock
    input wire logic clk,
    // Device pads
    input wire logic [47:0] pad_out,
    input wire logic [47:0] pad_oe,
    input gpp_pkg::gpp_pad_s [47:0] pad_ctl,
    // External drivers
    input wire logic [47:0] ext_oe,
    input wire logic [47:0] ext_val,
    // Resolved levels
    output logic [47:0] pad_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic flt_q = 1'b0;

    // Pads neither driven nor pulled toggle so a stale level never reads as valid
    always @(posedge clk) begin
        flt_q <= ~flt_q;
    end

    always_comb begin
        for (int i = 0; i < 48; i++) begin
            if (pad_oe[i]) begin
                pad_in[i] = pad_out[i];
            end else if (ext_oe[i]) begin
                pad_in[i] = ext_val[i];
            end else if (pad_ctl[i].pull_en) begin
                pad_in[i] = pad_ctl[i].pull_up;
            end else begin
                pad_in[i] = flt_q ^ i[0];
            end
        end
    end
endmodule

// File: sim/gpp_top_tb.sv
/*
  Self-checking bench of the port lines: table of line setups, then
  synchroniser delay, words, alternate routing and a second reset.
  Assumes gpp_top with default widths and the pin model beside it.
*/
`include "gpp_cfg.svh"

module gpp_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [5:0] ln;
        logic [6:0] ctl;
        logic lat;
        logic eoe;
        logic ev;
        logic xoe;
        logic xout;
        logic xpin;
    } gpp_row_s;

    localparam gpp_row_s ROWS [8] = '{
        '{6'd0, 7'h01, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1},
        '{6'd13, 7'h0f, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1},
        '{6'd14, 7'h01, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1},
        '{6'd27, 7'h0d, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1},
        '{6'd28, 7'h00, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0},
        '{6'd31, 7'h61, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0},
        '{6'd32, 7'h11, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1},
        '{6'd47, 7'h07, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0}
    };

    logic clk = 1'b0;
    logic rst = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata;
    logic [47:0] pad_in, pad_out, pad_oe, sync_in;
    gpp_pkg::gpp_pad_s [47:0] pad_ctl;
    logic [3:0] alt_out = 4'h0;
    logic [3:0] alt_in;
    logic [47:0] ext_oe = 48'h0;
    logic [47:0] ext_val = 48'h0;
    int failures = 0;
    int checked = 0;
    int cycles = 0;
    logic [5:0] ln;
    logic [6:0] c;
    logic io, oe, out, pin;

    gpp_top gpp_top_i (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe), .pad_ctl(pad_ctl),
        .alt_out(alt_out), .alt_in(alt_in), .sync_in(sync_in));

    gpp_pins_model gpp_pins_model_i (.clk(clk), .pad_out(pad_out),
        .pad_oe(pad_oe), .pad_ctl(pad_ctl), .ext_oe(ext_oe),
        .ext_val(ext_val), .pad_in(pad_in));

    always #5 clk = ~clk;

    // Whole run needs under two hundred cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures = failures + 1;
            final_report();
        end
    end

    task automatic chk(input string name, input logic [47:0] seen,
                       input logic [47:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Gap cycle after each strobe keeps one assignment per time step
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a,
                          input logic [15:0] exp);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(name, {32'h0, rdata}, {32'h0, exp});
        @(posedge clk);
    endtask

    task automatic settle();
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic final_report();
        $display("Checks made %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        // Rising edge at time zero so the flops reset before the first clock
        rst <= 1'b1;
        repeat (15) @(posedge clk);
        @(negedge clk);
        chk("rst_oe", pad_oe, 48'h0);
        chk("rst_pull", {47'h0, pad_ctl === '0}, 48'h1);
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int r = 0; r < 8; r++) begin
            ln = ROWS[r].ln;
            c = ROWS[r].ctl;
            io = ln >= 6'd14 && ln < 6'd28;
            ext_oe[ln] <= ROWS[r].eoe;
            ext_val[ln] <= ROWS[r].ev;
            wr_reg(`GPP_CTL_BASE + {2'b00, ln}, {9'h0, c});
            wr_reg(`GPP_BIT_BASE + {2'b00, ln}, {15'h0, ROWS[r].lat});
            oe = ROWS[r].xoe;
            out = ROWS[r].xout;
            pin = ROWS[r].xpin;
            settle();
            chk("pad_oe", {47'h0, pad_oe[ln]}, {47'h0, oe});
            chk("pad_out", {47'h0, pad_out[ln]}, {47'h0, out});
            chk("pad_ctl", {43'h0, pad_ctl[ln]}, {43'h0, c[6:2]});
            @(posedge clk);
            rd_chk("ctl_rb", `GPP_CTL_BASE + {2'b00, ln},
                   {9'h0, c & (io ? 7'h7c : 7'h7f)});
            rd_chk("bit_rb", `GPP_BIT_BASE + {2'b00, ln},
                   {14'h0, pin, ROWS[r].lat});
        end
        // Pin change must need exactly two edges to reach sync_in
        ext_val[28] <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        chk("sync_1st", {47'h0, sync_in[28]}, 48'h0);
        @(negedge clk);
        chk("sync_2nd", {47'h0, sync_in[28]}, 48'h1);
        @(posedge clk);
        wr_reg(`GPP_OUT_BASE + 8'h02, 16'hffff);
        rd_chk("out_c", `GPP_OUT_BASE + 8'h02, 16'h000f);
        rd_chk("out_a", `GPP_OUT_BASE, 16'h2001);
        rd_chk("out_d", `GPP_OUT_BASE + 8'h03, 16'h8001);
        rd_chk("unmapped", 8'h70, 16'h0000);
        alt_out <= 4'b0010;
        ext_oe[30:29] <= 2'b11;
        ext_val[30:29] <= 2'b01;
        wr_reg(`GPP_ROUTE_BASE, 16'h0060);
        wr_reg(`GPP_ROUTE_BASE + 8'h01, 16'h0060);
        settle();
        chk("alt_low_f", {47'h0, pad_out[32]}, 48'h0);
        @(posedge clk);
        wr_reg(`GPP_ROUTE_BASE, 16'h0040);
        settle();
        chk("alt_move", {46'h0, pad_out[32], pad_out[0]}, 48'h2);
        @(posedge clk);
        wr_reg(`GPP_ROUTE_BASE, 16'h0000);
        settle();
        chk("alt_free", {47'h0, pad_out[0]}, 48'h1);
        @(posedge clk);
        wr_reg(`GPP_INSEL_BASE + 8'h02, 16'h000e);
        settle();
        chk("alt_in_sel", {47'h0, alt_in[2]}, 48'h1);
        @(posedge clk);
        wr_reg(`GPP_INSEL_BASE + 8'h02, 16'h0030);
        settle();
        chk("alt_in_none", {47'h0, alt_in[2]}, 48'h0);
        @(posedge clk);
        rd_chk("in_c", `GPP_IN_BASE + 8'h02, 16'h000b);
        rst <= 1'b1;
        @(negedge clk);
        chk("rst2_oe", pad_oe, 48'h0);
        chk("rst2_pull", {47'h0, pad_ctl === '0}, 48'h1);
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_chk("rst2_ctl", `GPP_CTL_BASE + 8'd47, 16'h0000);
        rd_chk("rst2_out", `GPP_OUT_BASE, 16'h0000);
        final_report();
    end
endmodule
